// [logic/acs_top.v]
// Converter sequencer: APB registers, acquisition, discharge, SAR conversion and abort.
// Assumes an external comparator, sample array and input mux; pins synchronous to clk.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

module acs_top (
  input  wire        clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  input  wire        second_port_analog_reset_default,
  input  wire [3:0]  compare_mode_field,
  input  wire        cmp_special_event,
  input  wire        instr_retire,
  input  wire        ana_cmp_high,
  input  wire [12:0] pin_level,
  output reg  [3:0]  ana_channel_ff,
  output reg  [1:0]  ana_ref_sel_ff,
  output reg         ana_sample_ff,
  output reg         ana_discharge_ff,
  output reg         ana_hold_ff,
  output reg  [9:0]  ana_dac_ff,
  output reg         timer_clear_ff
);

  localparam [2:0] ST_OFF    = 3'd0;
  localparam [2:0] ST_DISCH  = 3'd1;
  localparam [2:0] ST_SAMPLE = 3'd2;
  localparam [2:0] ST_DELAY  = 3'd3;
  localparam [2:0] ST_ACQ    = 3'd4;
  localparam [2:0] ST_CONV   = 3'd5;
  localparam [2:0] ST_WAIT   = 3'd6;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [4:0]  tad_cnt_ff;
  reg  [4:0]  nxt_tad_cnt;
  reg         go_ff;
  reg         nxt_go;
  reg  [9:0]  sar_ff;
  reg  [9:0]  nxt_sar;
  reg  [7:0]  res_hi_ff;
  reg  [7:0]  nxt_res_hi;
  reg  [7:0]  res_lo_ff;
  reg  [7:0]  nxt_res_lo;
  reg         done_ff;
  reg         nxt_done;
  reg         on_ff;
  reg  [3:0]  chs_ff;
  reg  [1:0]  vcfg_ff;
  reg  [3:0]  pcfg_ff;
  reg         fmt_ff;
  reg  [2:0]  acqt_ff;
  reg  [2:0]  adcs_ff;
  reg  [9:0]  final_res;
  wire        tad_tick;
  wire [12:0] port_read;
  wire [2:0]  acc_idx;
  wire [2:0]  setup_idx;
  wire        apb_wr;
  wire        sev_hit;
  wire        wr_ctl;
  wire        go_set_req;
  wire        go_clr_req;
  wire [4:0]  acq_last;

  // Map an APB byte address onto a register index
  function [2:0] reg_index;
    input [7:0] addr;
    begin
      if (addr == `ACS_ADDR_RES_HI)
        reg_index = `ACS_IDX_RES_HI;
      else if (addr == `ACS_ADDR_RES_LO)
        reg_index = `ACS_IDX_RES_LO;
      else if (addr == `ACS_ADDR_CHAN_CTL)
        reg_index = `ACS_IDX_CHAN_CTL;
      else if (addr == `ACS_ADDR_REF_PORT)
        reg_index = `ACS_IDX_REF_PORT;
      else if (addr == `ACS_ADDR_TIMING)
        reg_index = `ACS_IDX_TIMING;
      else if (addr == `ACS_ADDR_STATUS)
        reg_index = `ACS_IDX_STATUS;
      else if (addr == `ACS_ADDR_PORT_RD)
        reg_index = `ACS_IDX_PORT_RD;
      else
        reg_index = `ACS_IDX_NONE;
    end
  endfunction

  // Acquisition length in bit periods, minus one; zero means manual
  function [4:0] acq_tads_last;
    input [2:0] code;
    begin
      case (code)
        3'b001:  acq_tads_last = 5'd1;
        3'b010:  acq_tads_last = 5'd3;
        3'b011:  acq_tads_last = 5'd5;
        3'b100:  acq_tads_last = 5'd7;
        3'b101:  acq_tads_last = 5'd11;
        3'b110:  acq_tads_last = 5'd15;
        3'b111:  acq_tads_last = 5'd19;
        default: acq_tads_last = 5'd0;
      endcase
    end
  endfunction

  assign acc_idx   = reg_index(paddr);
  assign setup_idx = reg_index(paddr);
  assign acq_last  = acq_tads_last(acqt_ff);
  assign apb_wr    = psel & penable & pready_ff & pwrite;
  assign wr_ctl    = apb_wr && (acc_idx == `ACS_IDX_CHAN_CTL);
  // Trigger only counts in the compare mode reserved for it
  assign sev_hit   = cmp_special_event && (compare_mode_field == `ACS_CMP_SEV_MODE);
  // Go is set by software or by the trigger while the converter is on
  assign go_set_req = (wr_ctl & pwdata[`ACS_GO_BIT] & pwdata[`ACS_ON_BIT]) | (sev_hit & on_ff);
  assign go_clr_req = wr_ctl & ~pwdata[`ACS_GO_BIT];

  acs_tad_gen u_tad (
    .clk     (clk),
    .rstn    (rstn),
    .clk_sel (adcs_ff),
    .restart (nxt_state != state_ff),
    .tick_ff (tad_tick)
  );

  acs_port_mask u_mask (
    .clk          (clk),
    .rstn         (rstn),
    .port_cfg     (pcfg_ff),
    .pin_level    (pin_level),
    .port_read_ff (port_read)
  );

  // Format the finished code into the result pair
  always @* begin
    final_res = {sar_ff[9:1], ana_cmp_high};
    if (fmt_ff) begin
      nxt_res_hi = {6'h00, final_res[9:8]};
      nxt_res_lo = final_res[7:0];
    end else begin
      nxt_res_hi = final_res[9:2];
      nxt_res_lo = {final_res[1:0], 6'h00};
    end
  end

  // Sequencer; channel and pin direction never enter any condition here
  always @* begin
    nxt_state   = state_ff;
    nxt_tad_cnt = tad_cnt_ff;
    nxt_sar     = sar_ff;
    nxt_done    = done_ff;
    nxt_go      = go_ff;
    if (go_set_req)
      nxt_go = 1'b1;
    else if (go_clr_req)
      nxt_go = 1'b0;
    if (apb_wr && (acc_idx == `ACS_IDX_STATUS) && pwdata[`ACS_DONE_BIT])
      nxt_done = 1'b0;
    case (state_ff)
      ST_OFF: begin
        nxt_go = 1'b0;
        if (on_ff)
          nxt_state = ST_DISCH;
      end
      ST_DISCH: begin
        if (tad_tick)
          nxt_state = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        nxt_tad_cnt = 5'd0;
        nxt_sar     = 10'h000;
        if (go_ff) begin
          if (acqt_ff == 3'b000)
            nxt_state = ST_DELAY;
          else
            nxt_state = ST_ACQ;
        end
      end
      ST_DELAY: begin
        if (!go_ff)
          nxt_state = ST_WAIT;
        else if (instr_retire)
          nxt_state = ST_CONV;
      end
      ST_ACQ: begin
        if (!go_ff) begin
          nxt_state   = ST_WAIT;
          nxt_tad_cnt = 5'd0;
        end else if (tad_tick) begin
          if (tad_cnt_ff == acq_last) begin
            nxt_state   = ST_CONV;
            nxt_tad_cnt = 5'd0;
          end else begin
            nxt_tad_cnt = tad_cnt_ff + 5'd1;
          end
        end
      end
      ST_CONV: begin
        if (!go_ff) begin
          nxt_state   = ST_WAIT;
          nxt_tad_cnt = 5'd0;
        end else if (tad_tick) begin
          // First period disconnects, then one bit decided per period
          if (tad_cnt_ff == {1'b0, `ACS_LAST_BIT_TAD}) begin
            nxt_sar     = final_res;
            nxt_state   = ST_WAIT;
            nxt_tad_cnt = 5'd0;
            nxt_done    = 1'b1;
            nxt_go      = sev_hit & on_ff;
          end else begin
            if (tad_cnt_ff != 5'd0)
              nxt_sar[4'd10 - tad_cnt_ff[3:0]] = ana_cmp_high;
            nxt_sar[4'd9 - tad_cnt_ff[3:0]] = 1'b1;
            nxt_tad_cnt = tad_cnt_ff + 5'd1;
          end
        end
      end
      ST_WAIT: begin
        if (tad_tick) begin
          if (tad_cnt_ff == {1'b0, `ACS_WAIT_TADS} - 5'd1)
            nxt_state = ST_DISCH;
          else
            nxt_tad_cnt = tad_cnt_ff + 5'd1;
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
    // Switching off abandons any work without touching the result
    if (!on_ff) begin
      nxt_state = ST_OFF;
      nxt_go    = 1'b0;
    end
  end

  // Sequencer state, flags and result pair
  always @(posedge clk) begin
    if (!rstn) begin
      state_ff   <= ST_OFF;
      tad_cnt_ff <= 5'd0;
      go_ff      <= 1'b0;
      sar_ff     <= 10'h000;
      done_ff    <= 1'b0;
      res_hi_ff  <= 8'h00;
      res_lo_ff  <= 8'h00;
    end else begin
      state_ff   <= nxt_state;
      tad_cnt_ff <= nxt_tad_cnt;
      go_ff      <= nxt_go;
      sar_ff     <= nxt_sar;
      done_ff    <= nxt_done;
      // Completion outranks a software write in the same cycle
      if (state_ff == ST_CONV && on_ff && go_ff && tad_tick &&
          tad_cnt_ff == {1'b0, `ACS_LAST_BIT_TAD}) begin
        res_hi_ff <= nxt_res_hi;
        res_lo_ff <= nxt_res_lo;
      end else begin
        if (apb_wr && acc_idx == `ACS_IDX_RES_HI)
          res_hi_ff <= pwdata[7:0];
        if (apb_wr && acc_idx == `ACS_IDX_RES_LO)
          res_lo_ff <= pwdata[7:0];
      end
    end
  end

  // Software configuration; port configuration reset follows the strap
  always @(posedge clk) begin
    if (!rstn) begin
      on_ff   <= 1'b0;
      chs_ff  <= 4'h0;
      vcfg_ff <= `ACS_VCFG_RST;
      pcfg_ff <= second_port_analog_reset_default ? `ACS_PCFG_RST_ANA : `ACS_PCFG_RST_DIG;
      fmt_ff  <= 1'b0;
      acqt_ff <= 3'b000;
      adcs_ff <= 3'b000;
    end else if (apb_wr) begin
      if (acc_idx == `ACS_IDX_CHAN_CTL) begin
        on_ff  <= pwdata[`ACS_ON_BIT];
        chs_ff <= pwdata[`ACS_CHS_MSB:`ACS_CHS_LSB];
      end else if (acc_idx == `ACS_IDX_REF_PORT) begin
        vcfg_ff <= pwdata[`ACS_VCFG_MSB:`ACS_VCFG_LSB];
        pcfg_ff <= pwdata[`ACS_PCFG_MSB:`ACS_PCFG_LSB];
      end else if (acc_idx == `ACS_IDX_TIMING) begin
        fmt_ff  <= pwdata[`ACS_FMT_BIT];
        acqt_ff <= pwdata[`ACS_ACQT_MSB:`ACS_ACQT_LSB];
        adcs_ff <= pwdata[`ACS_ADCS_MSB:`ACS_ADCS_LSB];
      end
    end
  end

  // APB: data is captured in setup so pready and prdata come from flops
  always @(posedge clk) begin
    if (!rstn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else if (psel && !penable) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= (setup_idx == `ACS_IDX_NONE);
      if (setup_idx == `ACS_IDX_RES_HI)
        prdata_ff <= {24'h000000, res_hi_ff};
      else if (setup_idx == `ACS_IDX_RES_LO)
        prdata_ff <= {24'h000000, res_lo_ff};
      else if (setup_idx == `ACS_IDX_CHAN_CTL)
        prdata_ff <= {26'h0000000, chs_ff, go_ff, on_ff};
      else if (setup_idx == `ACS_IDX_REF_PORT)
        prdata_ff <= {26'h0000000, vcfg_ff, pcfg_ff};
      else if (setup_idx == `ACS_IDX_TIMING)
        prdata_ff <= {24'h000000, fmt_ff, 1'b0, acqt_ff, adcs_ff};
      else if (setup_idx == `ACS_IDX_STATUS)
        prdata_ff <= {31'h00000000, done_ff};
      else if (setup_idx == `ACS_IDX_PORT_RD)
        prdata_ff <= {19'h00000, port_read};
      else
        prdata_ff <= 32'h00000000;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // Phase controls and DAC registered from the next state so they line up with it; channel and reference follow the configuration
  always @(posedge clk) begin
    if (!rstn) begin
      ana_channel_ff   <= 4'h0;
      ana_ref_sel_ff   <= 2'h0;
      ana_sample_ff    <= 1'b0;
      ana_discharge_ff <= 1'b0;
      ana_hold_ff      <= 1'b0;
      ana_dac_ff       <= 10'h000;
      timer_clear_ff   <= 1'b0;
    end else begin
      ana_channel_ff   <= chs_ff;
      ana_ref_sel_ff   <= vcfg_ff;
      ana_sample_ff    <= (nxt_state == ST_SAMPLE) || (nxt_state == ST_ACQ) || (nxt_state == ST_DELAY);
      ana_discharge_ff <= (nxt_state == ST_DISCH);
      ana_hold_ff      <= (nxt_state == ST_CONV);
      ana_dac_ff       <= nxt_sar;
      timer_clear_ff   <= sev_hit;
    end
  end

endmodule
`default_nettype wire

// [include/acs_map.vh]
// Register map, field positions, reset values and timing counts of the converter sequencer.
// Assumes a 125 MHz system clock and a 32-bit APB slave with one register per aligned word.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// APB byte addresses
`define ACS_ADDR_RES_HI    8'h00
`define ACS_ADDR_RES_LO    8'h04
`define ACS_ADDR_CHAN_CTL  8'h08
`define ACS_ADDR_REF_PORT  8'h0c
`define ACS_ADDR_TIMING    8'h10
`define ACS_ADDR_STATUS    8'h14
`define ACS_ADDR_PORT_RD   8'h18

// Register index codes returned by the address decoder
`define ACS_IDX_NONE       3'h0
`define ACS_IDX_RES_HI     3'h1
`define ACS_IDX_RES_LO     3'h2
`define ACS_IDX_CHAN_CTL   3'h3
`define ACS_IDX_REF_PORT   3'h4
`define ACS_IDX_TIMING     3'h5
`define ACS_IDX_STATUS     3'h6
`define ACS_IDX_PORT_RD    3'h7

// Channel control fields
`define ACS_ON_BIT         0
`define ACS_GO_BIT         1
`define ACS_CHS_LSB        2
`define ACS_CHS_MSB        5
// Reference and port configuration fields
`define ACS_PCFG_LSB       0
`define ACS_PCFG_MSB       3
`define ACS_VCFG_LSB       4
`define ACS_VCFG_MSB       5
// Timing and format fields
`define ACS_ADCS_LSB       0
`define ACS_ADCS_MSB       2
`define ACS_ACQT_LSB       3
`define ACS_ACQT_MSB       5
`define ACS_FMT_BIT        7
// Status fields
`define ACS_DONE_BIT       0

// Reset values
`define ACS_PCFG_RST_ANA   4'h0
`define ACS_PCFG_RST_DIG   4'h7
`define ACS_CHAN_RST       8'h00
`define ACS_TIMING_RST     8'h00
`define ACS_VCFG_RST       2'h0

// Channel and trigger constants
`define ACS_NUM_CHAN       13
`define ACS_CMP_SEV_MODE   4'hb

// Timing in conversion bit periods
`define ACS_CONV_TADS      4'd11
`define ACS_WAIT_TADS      4'd2
`define ACS_LAST_BIT_TAD   4'd10

// Internal RC bit period emulated from the system clock
`define ACS_CLK_PERIOD_NS  8
`define ACS_RC_TAD_NS      1200
`define ACS_RC_TAD_CYC     (`ACS_RC_TAD_NS / `ACS_CLK_PERIOD_NS)
// Divider compare value for the RC bit period: one less than its cycle count
`define ACS_RC_TAD_LAST    8'd149

`endif

// [logic/acs_tad_gen.v]
// Conversion bit period divider: one-cycle tick per bit period.
// Assumes a synchronous restart from the sequencer at each phase change.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

module acs_tad_gen (
  input  wire       clk,
  input  wire       rstn,
  input  wire [2:0] clk_sel,
  input  wire       restart,
  output reg        tick_ff
);

  reg [7:0] cnt_ff;
  wire [7:0] last_cnt;

  // Cycles per bit period minus one for each clock select code
  function [7:0] tad_last;
    input [2:0] sel;
    begin
      if (sel[1:0] == 2'b11)
        tad_last = `ACS_RC_TAD_LAST;
      else if (sel == 3'b000)
        tad_last = 8'd1;
      else if (sel == 3'b100)
        tad_last = 8'd3;
      else if (sel == 3'b001)
        tad_last = 8'd7;
      else if (sel == 3'b101)
        tad_last = 8'd15;
      else if (sel == 3'b010)
        tad_last = 8'd31;
      else
        tad_last = 8'd63;
    end
  endfunction

  assign last_cnt = tad_last(clk_sel);

  // Restart begins every phase on a fresh full bit period
  always @(posedge clk) begin
    if (!rstn || restart) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= last_cnt) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 8'd1;
      tick_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [logic/acs_port_mask.v]
// Port read masking: pins set up as analog channels read back as zero.
// Assumes pin levels already synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

module acs_port_mask (
  input  wire        clk,
  input  wire        rstn,
  input  wire [3:0]  port_cfg,
  input  wire [12:0] pin_level,
  output reg  [12:0] port_read_ff
);

  // Low channels are analog; higher codes free more pins for digital use
  function [12:0] analog_mask;
    input [3:0] cfg;
    integer i;
    reg [4:0] cnt;
    begin
      cnt = (cfg <= 4'd2) ? 5'd13 : (5'd15 - {1'b0, cfg});
      for (i = 0; i < `ACS_NUM_CHAN; i = i + 1)
        analog_mask[i] = (i < cnt);
    end
  endfunction

  // Analog pins read low whatever level sits on them
  always @(posedge clk) begin
    if (!rstn)
      port_read_ff <= 13'h0000;
    else
      port_read_ff <= pin_level & ~analog_mask(port_cfg);
  end

endmodule
`default_nettype wire

// [bench/acs_top_chk.sv]
// Checker for the sequencer's APB handshake, trigger and analog phase outputs.
// Sees only the top module's ports; bound to every instance below.
`timescale 1ns/1ps
`default_nettype none
module acs_top_chk (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready_ff,
  input wire logic       pslverr_ff,
  input wire logic [3:0] compare_mode_field,
  input wire logic       cmp_special_event,
  input wire logic       ana_sample_ff,
  input wire logic       ana_discharge_ff,
  input wire logic       ana_hold_ff,
  input wire logic       timer_clear_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Trigger in the periodic mode, whatever the converter on bit holds
  wire logic trig_b = cmp_special_event && compare_mode_field == 4'hb;

  AST_TMR_CLR: assert property (trig_b |=> timer_clear_ff)
    else $error("timer clear missing after trigger");
  AST_TMR_QUIET: assert property (!trig_b |=> !timer_clear_ff)
    else $error("timer clear without trigger");
  AST_READY: assert property (psel && !penable |=> pready_ff)
    else $error("no ready in first access cycle");
  AST_READY_PULSE: assert property (pready_ff |=> !pready_ff)
    else $error("ready held longer than one cycle");
  AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h18 |=> pslverr_ff && pready_ff)
    else $error("unmapped address not refused");
  AST_HOLD_ALONE: assert property (ana_hold_ff |-> !ana_sample_ff && !ana_discharge_ff)
    else $error("array sampled or emptied while converting");
  AST_DISCH_FIRST: assert property ($rose(ana_sample_ff) |-> $past(ana_discharge_ff) || $past(ana_discharge_ff, 2))
    else $error("sample began without discharge");
  AST_CONV_WAIT: assert property ($fell(ana_hold_ff) |-> !ana_sample_ff [*5])
    else $error("acquisition resumed before the wait");
  AST_RESAMPLE: assert property ($fell(ana_discharge_ff) |-> ##[0:1] ana_sample_ff)
    else $error("sampling did not follow discharge");

  // Main scenarios reached
  cover property (trig_b && ana_sample_ff);
  cover property ($fell(ana_hold_ff));
  cover property (pslverr_ff);
endmodule
bind acs_top acs_top_chk u_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .compare_mode_field(compare_mode_field),
  .cmp_special_event(cmp_special_event), .ana_sample_ff(ana_sample_ff),
  .ana_discharge_ff(ana_discharge_ff), .ana_hold_ff(ana_hold_ff), .timer_clear_ff(timer_clear_ff));
`default_nettype wire

// [bench/acs_ana_model.sv]
// Analog side model: input multiplexer, sample array and comparator.
// Assumes the bench drives one 10-bit level per channel.
`timescale 1ns/1ps
`default_nettype none
module acs_ana_model (
  input  wire logic         clk,
  input  wire logic [159:0] levels,
  input  wire logic [3:0]   ana_channel_ff,
  input  wire logic         ana_sample_ff,
  input  wire logic         ana_discharge_ff,
  input  wire logic         ana_hold_ff,
  input  wire logic [9:0]   ana_dac_ff,
  output logic              ana_cmp_high
);
  logic [9:0] vhold_ff = 10'h000;
  logic       junk_ff = 1'b0;
  // Charge tracks the selected pin while sampling and empties on discharge
  always @(posedge clk) begin
    if (ana_discharge_ff)
      vhold_ff <= 10'h000;
    else if (ana_sample_ff)
      vhold_ff <= levels[ana_channel_ff*10 +: 10];
    junk_ff <= ~junk_ff;
  end
  // Outside a conversion the output means nothing, so it toggles to expose misuse
  assign ana_cmp_high = ana_hold_ff ? (vhold_ff >= ana_dac_ff) : junk_ff;
endmodule
`default_nettype wire

// [bench/tb_adc_conversion_sequencer.sv]
// Self-checking bench: registers, port masking, conversions, abort and trigger.
// Assumes the design, the analog model and the checker compile before it.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_adc_conversion_sequencer;
  logic         clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic         second_port_analog_reset_default = 1;
  logic [7:0]   paddr = 0;
  logic [31:0]  pwdata = 0, prdata_ff;
  logic         pready_ff, pslverr_ff, ana_cmp_high, timer_clear_ff;
  logic [3:0]   compare_mode_field = 0, ana_channel_ff;
  logic         cmp_special_event = 0, instr_retire = 0;
  logic [12:0]  pin_level = 0;
  logic         ana_sample_ff, ana_discharge_ff, ana_hold_ff;
  logic [9:0]   ana_dac_ff;
  logic [1:0]   ana_ref_sel_ff;
  logic [159:0] levels = 0;
  logic [32:0]  expq[$], ex;
  int           num_errors = 0, cmp_count = 0;

  acs_top dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff,
    .pslverr_ff, .second_port_analog_reset_default, .compare_mode_field, .cmp_special_event,
    .instr_retire, .ana_cmp_high, .pin_level, .ana_channel_ff, .ana_ref_sel_ff, .ana_sample_ff,
    .ana_discharge_ff, .ana_hold_ff, .ana_dac_ff, .timer_clear_ff);
  acs_ana_model u_ana (.clk, .levels, .ana_channel_ff, .ana_sample_ff, .ana_discharge_ff,
    .ana_hold_ff, .ana_dac_ff, .ana_cmp_high);

  // 125 MHz system clock
  initial begin
    forever #4 clk = ~clk;
  end

  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer; the request is held until ready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
    if (!w)
      expq.push_back(e);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready_ff !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1, {24'h0, d}, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [12:0] d);
    apb(a, 0, 32'h0, {20'h0, d});
  endtask

  // Read data is judged in order against the notes the driver queued
  always @(posedge clk) begin
    if (psel && penable && pready_ff === 1'b1 && !pwrite) begin
      ex = expq.pop_front();
      `CHK({pslverr_ff, prdata_ff}, ex)
    end
  end

  // Bounded wait for sample (s=0) or hold (s=1) to reach v; n counts edges
  task automatic wt(input int s, input logic v, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      if ((s ? ana_hold_ff : ana_sample_ff) === v)
        break;
      @(posedge clk);
    end
    `CHK(n < lim, 1'b1)
  endtask

  function automatic int acq(input logic [2:0] c);
    int t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    return t[c];
  endfunction

  // Clocks per bit period for each clock select code
  function automatic int tck(input logic [2:0] c);
    int t[8] = '{2, 8, 32, 150, 4, 16, 64, 150};
    return t[c];
  endfunction

  // One conversion of a random channel; cs picks the bit period clock
  task automatic conv(input logic [2:0] aq, input logic fmt, input logic trg, input logic [2:0] cs);
    int n, m, tc;
    logic [9:0] v;
    logic [3:0] ch;
    tc = tck(cs);
    ch = 4'($urandom % 13);
    v = 10'($urandom);
    levels[ch*10 +: 10] <= v;
    wr(`ACS_ADDR_TIMING, {fmt, 1'b0, aq, cs});
    wr(`ACS_ADDR_CHAN_CTL, {2'b00, ch, 2'b01});
    wt(0, 1, 600, n);
    if (trg) begin
      compare_mode_field <= 4'hb;
      cmp_special_event <= 1;
      @(posedge clk);
      cmp_special_event <= 0;
    end else
      wr(`ACS_ADDR_CHAN_CTL, {2'b00, ch, 2'b11});
    if (aq == 0) begin
      repeat (10) @(posedge clk);
      `CHK(ana_hold_ff, 1'b0)
      instr_retire <= 1;
      @(posedge clk);
      instr_retire <= 0;
    end
    wt(1, 1, 24 * tc, n);
    if (aq != 0) `CHK(n >= tc * acq(aq) && n <= tc * acq(aq) + 3, 1'b1)
    wt(1, 0, 12 * tc + 4, m);
    `CHK(m >= 11 * tc - 1 && m <= 11 * tc + 1, 1'b1)
    rd(`ACS_ADDR_RES_HI, fmt ? {11'h0, v[9:8]} : {5'h0, v[9:2]});
    rd(`ACS_ADDR_RES_LO, fmt ? {5'h0, v[7:0]} : {5'h0, v[1:0], 6'h0});
    rd(`ACS_ADDR_STATUS, 13'h1);
    rd(`ACS_ADDR_CHAN_CTL, {7'h0, ch, 2'b01});
    wr(`ACS_ADDR_STATUS, 8'h01);
    rd(`ACS_ADDR_STATUS, 13'h0);
  endtask

  // Watchdog, well beyond the roughly twelve thousand cycles the sequence needs
  initial begin
    #500000;
    num_errors++;
    conclude();
  end

  // Main sequence
  initial begin
    int n;
    void'($urandom(20740));
    repeat (8) @(posedge clk);
    rstn <= 1;
    rd(`ACS_ADDR_CHAN_CTL, 13'h0);
    rd(`ACS_ADDR_TIMING, 13'h0);
    rd(`ACS_ADDR_REF_PORT, 13'h0);
    rd(`ACS_ADDR_RES_HI, 13'h0);
    apb(8'h1c, 0, 32'h0, {1'b1, 32'h0});
    apb(8'h20, 1, 32'hff, 33'h0);
    // Every port configuration code, random pin levels
    for (int c = 0; c < 16; c++) begin
      pin_level <= 13'($urandom);
      wr(`ACS_ADDR_REF_PORT, {2'b00, 2'(c), 4'(c)});
      repeat (3) @(posedge clk);
      `CHK(ana_ref_sel_ff, 2'(c))
      rd(`ACS_ADDR_PORT_RD, pin_level & ~13'((1 << (c <= 2 ? 13 : 15 - c)) - 1));
    end
    // All pins now digital, yet randomly chosen channels still convert
    for (int a = 1; a < 8; a++) conv(3'(a), a[0], 1'b0, 3'(a));
    conv(3'h0, 1'b1, 1'b0, 3'h0);
    conv(3'h2, 1'b0, 1'b1, 3'h0);
    // Abort mid-conversion after software wrote the result pair
    wr(`ACS_ADDR_RES_HI, 8'h5a);
    wr(`ACS_ADDR_RES_LO, 8'ha5);
    wr(`ACS_ADDR_TIMING, 8'h08);
    wt(0, 1, 400, n);
    wr(`ACS_ADDR_CHAN_CTL, 8'h07);
    wt(1, 1, 100, n);
    repeat (6) @(posedge clk);
    wr(`ACS_ADDR_CHAN_CTL, 8'h05);
    repeat (2) @(posedge clk);
    `CHK(ana_hold_ff, 1'b0)
    rd(`ACS_ADDR_RES_HI, 13'h5a);
    rd(`ACS_ADDR_RES_LO, 13'ha5);
    rd(`ACS_ADDR_STATUS, 13'h0);
    wt(0, 1, 400, n);
    // Trigger with converter off, then in a mode that is not the periodic one
    for (int k = 0; k < 2; k++) begin
      wr(`ACS_ADDR_CHAN_CTL, {7'h02, 1'(k)});
      wt(0, 1'(k), 400, n);
      compare_mode_field <= k ? 4'h3 : 4'hb;
      cmp_special_event <= 1;
      @(posedge clk);
      cmp_special_event <= 0;
      @(posedge clk);
      `CHK(timer_clear_ff, 1'(k == 0))
      repeat (29) @(posedge clk);
      `CHK(ana_hold_ff, 1'b0)
      rd(`ACS_ADDR_CHAN_CTL, {12'h002, 1'(k)});
    end
    // Second reset with the strap low: port configuration comes up 7, pins 8 to 12 digital
    rstn <= 0;
    second_port_analog_reset_default <= 0;
    repeat (8) @(posedge clk);
    rstn <= 1;
    rd(`ACS_ADDR_REF_PORT, 13'h7);
    conclude();
  end
endmodule
`default_nettype wire
